// ===== design/mreg_cfg.svh
`ifndef MREG_CFG_SVH
`define MREG_CFG_SVH

`define MREG_ADDR_ID 8'h40
`define MREG_ADDR_RSVD 8'h41
`define MREG_ADDR_X_LOW 8'h42
`define MREG_ADDR_X_HIGH 8'h43
`define MREG_ADDR_Y_LOW 8'h44
`define MREG_ADDR_Y_HIGH 8'h45
`define MREG_ADDR_Z_LOW 8'h46
`define MREG_ADDR_Z_HIGH 8'h47
`define MREG_ADDR_HALL_LOW 8'h48
`define MREG_ADDR_HALL_HIGH 8'h49

// Arbitrary identification value
`define MREG_CHIP_IDENTITY 8'h5a

`define MREG_XY_W 13
`define MREG_Z_W 15
`define MREG_HALL_W 14

`define MREG_BYTE_ZERO 8'h00
`define MREG_FIX0_2 2'h0
`define MREG_FIX0_1 1'h0
// All data zero, three self-test flags high
`define MREG_RESULT_RST 58'h7

`endif

// ===== design/mreg_pkg.sv
`include "mreg_cfg.svh"

package mreg_pkg;

  typedef struct packed {
    logic [`MREG_XY_W-1:0] x;
    logic [`MREG_XY_W-1:0] y;
    logic [`MREG_Z_W-1:0] z;
    logic [`MREG_HALL_W-1:0] hall;
    logic x_selftest_flag;
    logic y_selftest_flag;
    logic z_selftest_flag;
  } mreg_result_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mreg_req_t;

  typedef enum logic {
    MREG_SUSPEND = 1'b0,
    MREG_SLEEP = 1'b1
  } mreg_pwr_t;

endpackage : mreg_pkg

// ===== design/mreg_read_mux.sv
`include "mreg_cfg.svh"

module mreg_read_mux (
  input wire logic [7:0] addr,
  input wire mreg_pkg::mreg_result_t fields,
  input wire logic new_result_flag,
  input wire logic id_open,
  output logic [7:0] rdata
);

  always_comb begin
    case (addr)
      `MREG_ADDR_ID: begin
        rdata = id_open ? `MREG_CHIP_IDENTITY : `MREG_BYTE_ZERO;
      end
      `MREG_ADDR_X_LOW: begin
        rdata = {fields.x[4:0], `MREG_FIX0_2, fields.x_selftest_flag};
      end
      `MREG_ADDR_X_HIGH: begin
        rdata = fields.x[12:5];
      end
      `MREG_ADDR_Y_LOW: begin
        rdata = {fields.y[4:0], `MREG_FIX0_2, fields.y_selftest_flag};
      end
      `MREG_ADDR_Y_HIGH: begin
        rdata = fields.y[12:5];
      end
      `MREG_ADDR_Z_LOW: begin
        rdata = {fields.z[6:0], fields.z_selftest_flag};
      end
      `MREG_ADDR_Z_HIGH: begin
        rdata = fields.z[14:7];
      end
      `MREG_ADDR_HALL_LOW: begin
        rdata = {fields.hall[5:0], `MREG_FIX0_1, new_result_flag};
      end
      `MREG_ADDR_HALL_HIGH: begin
        rdata = fields.hall[13:6];
      end
      // Reserved slot and unmapped offsets read zero
      default: begin
        rdata = `MREG_BYTE_ZERO;
      end
    endcase
  end

endmodule : mreg_read_mux

// ===== design/mreg_bank.sv
// Notes on behaviour
// - The identification byte reads back only while the power state is sleep, else zero.
// - The identification register holds a fixed 8-bit code that writes never change.
// - X field is 13 bits, bits 4..0 in low bits 7..3, bits 12..5 in high, low bits 2..1 zero.
// - Y field is 13 bits, bits 4..0 in low bits 7..3, bits 12..5 in high, low bits 2..1 zero.
// - Z field is 15 bits, bits 6..0 in low bits 7..1 and bits 14..7 in the high register.
// - Each axis low register carries its self-test flag in bit 0, one after reset.
// - Hall resistance bits 5..0 sit in bits 7..2 of the hall low register, bit 1 reads zero.
// - Bit 0 of the hall low register is the new result flag, set when fresh results land.
// - The slot right after the identification register is reserved and reads zero.
// - Hall resistance bits 13..6 sit in the register after the hall low register.
// - Setting the power control bit moves suspend to sleep, clearing it returns to suspend.
`include "mreg_cfg.svh"

module mreg_bank (
  input wire logic clk,
  input wire logic rst,
  input wire mreg_pkg::mreg_req_t reg_req,
  input wire logic result_valid,
  input wire mreg_pkg::mreg_result_t result_data,
  input wire logic power_ctl,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic awake,
  output logic new_result_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic is_read(input mreg_pkg::mreg_req_t r);
    is_read = r.valid && !r.write;
  endfunction : is_read

  function automatic logic read_at(input mreg_pkg::mreg_req_t r, input logic [7:0] a);
    read_at = is_read(r) && (r.addr == a);
  endfunction : read_at

  mreg_pkg::mreg_pwr_t pwr_q;
  mreg_pkg::mreg_pwr_t pwr_d;
  mreg_pkg::mreg_result_t fields_q;
  logic new_result_flag_q;
  logic [7:0] mux_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Power state follows the control bit one edge later
  always_comb begin
    unique case (pwr_q)
      mreg_pkg::MREG_SUSPEND: begin
        pwr_d = power_ctl ? mreg_pkg::MREG_SLEEP : mreg_pkg::MREG_SUSPEND;
      end
      mreg_pkg::MREG_SLEEP: begin
        pwr_d = power_ctl ? mreg_pkg::MREG_SLEEP : mreg_pkg::MREG_SUSPEND;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_q <= mreg_pkg::MREG_SUSPEND;
      awake <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      awake <= (pwr_d == mreg_pkg::MREG_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Results only enter from the measurement side; the host has no write path
  always_ff @(posedge clk) begin
    if (rst) begin
      fields_q <= `MREG_RESULT_RST;
    end else if (result_valid) begin
      fields_q <= result_data;
    end
  end

  // Set wins over the clear so a result landing during the read is not lost
  always_ff @(posedge clk) begin
    if (rst) begin
      new_result_flag_q <= 1'b0;
    end else if (result_valid) begin
      new_result_flag_q <= 1'b1;
    end else if (read_at(reg_req, `MREG_ADDR_HALL_LOW)) begin
      new_result_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      new_result_flag <= 1'b0;
    end else begin
      new_result_flag <= result_valid | (new_result_flag_q & ~read_at(reg_req, `MREG_ADDR_HALL_LOW));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  mreg_read_mux u_mux (
    .addr(reg_req.addr),
    .fields(fields_q),
    .new_result_flag(new_result_flag_q),
    .id_open(pwr_q == mreg_pkg::MREG_SLEEP),
    .rdata(mux_rdata)
  );

  // Read answers one edge after the request; writes get no answer
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= `MREG_BYTE_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= is_read(reg_req);
      if (is_read(reg_req)) begin
        reg_rdata <= mux_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_id_gated;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_ID) && pwr_q == mreg_pkg::MREG_SUSPEND
      |=> reg_rvalid && reg_rdata == `MREG_BYTE_ZERO;
  endproperty
  a_id_gated: assert property (p_id_gated) else $error("id readable in suspend");

  property p_id_value;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_ID) && awake |=> reg_rdata == `MREG_CHIP_IDENTITY;
  endproperty
  a_id_value: assert property (p_id_value) else $error("wrong id byte");

  property p_x_low;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_X_LOW)
      |=> reg_rdata == {$past(fields_q.x[4:0]), `MREG_FIX0_2, $past(fields_q.x_selftest_flag)};
  endproperty
  a_x_low: assert property (p_x_low) else $error("x low byte wrong");

  property p_x_high;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_X_HIGH) |=> reg_rdata == $past(fields_q.x[12:5]);
  endproperty
  a_x_high: assert property (p_x_high) else $error("x high byte wrong");

  property p_y_low;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_Y_LOW)
      |=> reg_rdata == {$past(fields_q.y[4:0]), `MREG_FIX0_2, $past(fields_q.y_selftest_flag)};
  endproperty
  a_y_low: assert property (p_y_low) else $error("y low byte wrong");

  property p_y_high;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_Y_HIGH) |=> reg_rdata == $past(fields_q.y[12:5]);
  endproperty
  a_y_high: assert property (p_y_high) else $error("y high byte wrong");

  property p_z_pair;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_Z_LOW) && !result_valid
      ##1 read_at(reg_req, `MREG_ADDR_Z_HIGH) && !result_valid
      |=> {reg_rdata, $past(reg_rdata[7:1])} == fields_q.z;
  endproperty
  a_z_pair: assert property (p_z_pair) else $error("z value split wrong");

  property p_z_low;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_Z_LOW)
      |=> reg_rdata == {$past(fields_q.z[6:0]), $past(fields_q.z_selftest_flag)};
  endproperty
  a_z_low: assert property (p_z_low) else $error("z low byte wrong");

  property p_selftest_reset;
    @(posedge clk)
    rst ##1 !rst && !$past(result_valid)
      |-> fields_q.x_selftest_flag && fields_q.y_selftest_flag && fields_q.z_selftest_flag;
  endproperty
  a_selftest_reset: assert property (p_selftest_reset) else $error("self-test flag not one");

  property p_hall_low;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_HALL_LOW)
      |=> reg_rdata[1] == 1'b0 && reg_rdata[7:2] == $past(fields_q.hall[5:0]);
  endproperty
  a_hall_low: assert property (p_hall_low) else $error("hall low byte wrong");

  property p_new_result_flag_set;
    @(posedge clk) disable iff (rst)
    result_valid |=> new_result_flag_q ##0 new_result_flag;
  endproperty
  a_new_result_flag_set: assert property (p_new_result_flag_set) else $error("new result flag not set");

  property p_new_result_flag_clear;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_HALL_LOW) && !result_valid |=> !new_result_flag_q && !new_result_flag;
  endproperty
  a_new_result_flag_clear: assert property (p_new_result_flag_clear) else $error("new result flag not cleared");

  property p_reserved;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_RSVD) |=> reg_rdata == `MREG_BYTE_ZERO;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved slot not zero");

  property p_hall_high;
    @(posedge clk) disable iff (rst)
    read_at(reg_req, `MREG_ADDR_HALL_HIGH) |=> reg_rdata == $past(fields_q.hall[13:6]);
  endproperty
  a_hall_high: assert property (p_hall_high) else $error("hall high byte wrong");

  property p_power;
    @(posedge clk) disable iff (rst)
    $changed(power_ctl) |=> awake == $past(power_ctl)
      ##1 awake == $past(power_ctl, 2) || $changed(awake);
  endproperty
  a_power: assert property (p_power) else $error("power state did not follow");

  property p_write_ignored;
    @(posedge clk) disable iff (rst)
    reg_req.valid && reg_req.write && !result_valid |=> $stable(fields_q) && !reg_rvalid;
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write changed data");

  c_id_read: cover property (@(posedge clk) disable iff (rst)
    awake ##0 read_at(reg_req, `MREG_ADDR_ID) ##1 reg_rvalid);
  c_result_read: cover property (@(posedge clk) disable iff (rst)
    result_valid ##1 read_at(reg_req, `MREG_ADDR_HALL_LOW) ##1 !new_result_flag_q);
  c_set_beats_clear: cover property (@(posedge clk) disable iff (rst)
    result_valid && read_at(reg_req, `MREG_ADDR_HALL_LOW) ##1 new_result_flag_q);
  c_power_cycle: cover property (@(posedge clk) disable iff (rst)
    awake ##1 !awake);

endmodule : mreg_bank

// ===== bench/mreg_host.sv
module mreg_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output mreg_pkg::mreg_req_t reg_req
);
  timeunit 1ns;
  timeprecision 1ns;

  initial reg_req = '{1'b0, 1'b0, 8'h00, 8'h00};

  ////////////////////////////////////////////////////////////
  // One-cycle read; answer looked for at each falling edge
  // Request stays up after the answer, so back to back reads need no gap
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    reg_req <= '{1'b1, 1'b0, a, 8'h00};
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk);
      ok = (reg_rvalid === 1'b1);
    end
    d = reg_rdata;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req <= '{1'b1, 1'b1, a, d};
    @(negedge clk);
  endtask : wr

  // Idle bus shows inverted stale values, so nothing may rely on them
  task automatic idle;
    reg_req <= '{1'b0, 1'b0, ~reg_req.addr, ~reg_req.wdata};
    @(negedge clk);
  endtask : idle
endmodule : mreg_host

// ===== bench/magnetometer_id_and_data_regs_tb_top.sv
`include "mreg_cfg.svh"

`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); fails++; end end

module magnetometer_id_and_data_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic result_valid = 1'b0;
  logic power_ctl = 1'b0;
  mreg_pkg::mreg_result_t res = '0;
  mreg_pkg::mreg_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic awake;
  logic nrf;
  int fails = 0;
  int total_checks = 0;

  always #50 clk = ~clk;

  mreg_bank uut (
    .clk(clk),
    .rst(rst),
    .reg_req(req),
    .result_valid(result_valid),
    .result_data(res),
    .power_ctl(power_ctl),
    .reg_rdata(rdata),
    .reg_rvalid(rvalid),
    .awake(awake),
    .new_result_flag(nrf)
  );

  mreg_host host (
    .clk(clk),
    .reg_rdata(rdata),
    .reg_rvalid(rvalid),
    .reg_req(req)
  );

  ////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic rchk(input logic [7:0] a, input logic [7:0] ex);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    `CHK("read answer", 1'b1, ok)
    if (!ok) begin
      end_sim();
    end
    `CHK("read data", ex, d)
  endtask : rchk

  ////////////////////////////////////////////////////////////
  task automatic reset_values;
    `CHK("new result", 1'b0, nrf)
    for (int i = 0; i < 3; i++) rchk(8'h42 + 8'(2 * i), 8'h01);
    rchk(`MREG_ADDR_HALL_LOW, 8'h00);
    rchk(`MREG_ADDR_ID, 8'h00);
    `CHK("awake", 1'b0, awake)
  endtask : reset_values

  task automatic power_and_id;
    power_ctl = 1'b1;
    host.idle();
    `CHK("awake", 1'b1, awake)
    rchk(`MREG_ADDR_ID, `MREG_CHIP_IDENTITY);
    host.wr(`MREG_ADDR_ID, ~`MREG_CHIP_IDENTITY);
    `CHK("write answer", 1'b0, rvalid)
    rchk(`MREG_ADDR_ID, `MREG_CHIP_IDENTITY);
    rchk(`MREG_ADDR_RSVD, 8'h00);
    power_ctl = 1'b0;
    host.idle();
    `CHK("awake", 1'b0, awake)
    rchk(`MREG_ADDR_ID, 8'h00);
  endtask : power_and_id

  task automatic results;
    res = '{13'h15a5, 13'h0a5a, 15'h5a3c, 14'h2b6d, 1'b0, 1'b1, 1'b0};
    result_valid = 1'b1;
    host.idle();
    result_valid = 1'b0;
    // One cycle of slack, flag must stand until read anyway
    host.idle();
    `CHK("new result", 1'b1, nrf)
    host.wr(`MREG_ADDR_X_LOW, 8'hff);
    `CHK("write answer", 1'b0, rvalid)
    rchk(`MREG_ADDR_X_LOW, {res.x[4:0], 2'b00, res.x_selftest_flag});
    rchk(`MREG_ADDR_X_HIGH, res.x[12:5]);
    rchk(`MREG_ADDR_Y_LOW, {res.y[4:0], 2'b00, res.y_selftest_flag});
    rchk(`MREG_ADDR_Y_HIGH, res.y[12:5]);
    rchk(`MREG_ADDR_Z_LOW, {res.z[6:0], res.z_selftest_flag});
    rchk(`MREG_ADDR_Z_HIGH, res.z[14:7]);
    rchk(`MREG_ADDR_HALL_LOW, {res.hall[5:0], 1'b0, 1'b1});
    rchk(`MREG_ADDR_HALL_HIGH, res.hall[13:6]);
    `CHK("new result", 1'b0, nrf)
    rchk(`MREG_ADDR_HALL_LOW, {res.hall[5:0], 2'b00});
    // New result in the same cycle as the clearing read: the set must win
    result_valid = 1'b1;
    rchk(`MREG_ADDR_HALL_LOW, {res.hall[5:0], 2'b00});
    result_valid = 1'b0;
    host.idle();
    `CHK("new result", 1'b1, nrf)
    rchk(`MREG_ADDR_HALL_LOW, {res.hall[5:0], 2'b01});
    host.idle();
  endtask : results

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    reset_values();
    power_and_id();
    results();
    end_sim();
  end
endmodule : magnetometer_id_and_data_regs_tb_top
